// [ctm_pkg.sv]
// constants, types and helpers for the data lane timing and byte-to-lane map
`default_nettype none
package ctm_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int UI_PER_TICK   = 8;
  localparam int NUM_LANES     = 4;
  localparam int CYC_W         = 5;
  localparam int TICK_W        = 3;

  // -------------------------------------------------
  // register map
  // -------------------------------------------------
  localparam logic [7:0] CLK_TIMING_OFS = 8'h63;
  localparam logic [7:0] HS_TIMING_OFS  = 8'h64;
  localparam logic [7:0] LANE_CTRL_OFS  = 8'h65;
  localparam logic [7:0] LANE_MAP_OFS   = 8'h66;
  localparam logic [7:0] SPARE_OFS      = 8'h67;
  localparam logic [7:0] CLK_TIMING_RST = 8'h00;
  localparam logic [7:0] HS_TIMING_RST  = 8'h00;
  localparam logic [7:0] LANE_CTRL_RST  = 8'h17;
  localparam logic [7:0] LANE_MAP_RST   = 8'he4;
  localparam logic [7:0] SPARE_RST      = 8'h00;
  localparam logic [3:0] LANE_CTRL_RSVD = 4'h7;
  localparam int PREP_POS    = 6;
  localparam int ZERO_POS    = 4;
  localparam int TRAIL_POS   = 2;
  localparam int LPX_POS     = 0;
  localparam int CLKPREP_POS = 6;
  localparam int EN_SRC_POS  = 6;
  localparam int COUNT_POS   = 4;

  // -------------------------------------------------
  // timing tables, index is the field code
  // -------------------------------------------------
  localparam int PREP_NS    [4] = '{64, 72, 80, 80};
  localparam int ZERO_NS    [4] = '{160, 176, 200, 240};
  localparam int TRAIL_NS   [4] = '{64, 80, 96, 120};
  localparam int LPX_NS     [4] = '{64, 128, 192, 256};
  localparam int CLKPREP_NS [4] = '{64, 72, 80, 88};
  localparam int PREP_UI  = 4;
  localparam int ZERO_UI  = 32;
  localparam int TRAIL_UI = 8;
  localparam logic [7:0] SYNC_BYTE = 8'hb8;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_LPX      = 3'b001,
    ST_CLK_PREP = 3'b010,
    ST_PREP     = 3'b011,
    ST_ZERO     = 3'b100,
    ST_SYNC     = 3'b101,
    ST_PAYLOAD  = 3'b110,
    ST_TRAIL    = 3'b111
  } ctm_state_t;

  typedef enum logic [1:0] {
    LANE_STOP = 2'b00,
    LANE_LP01 = 2'b01,
    LANE_LP00 = 2'b10,
    LANE_HS   = 2'b11
  } ctm_lane_mode_t;

  typedef struct packed {
    ctm_lane_mode_t mode;
    logic [7:0]     data;
  } ctm_lane_out_t;

  typedef struct packed {
    logic [7:0] clk_timing;
    logic [7:0] hs_timing;
    logic [7:0] lane_ctrl;
    logic [7:0] lane_map;
  } ctm_cfg_t;

  // least time rounds up to whole clock cycles
  function automatic int cyc_of(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  function automatic int tick_of(input int ui);
    return (ui + UI_PER_TICK - 1) / UI_PER_TICK;
  endfunction

  function automatic logic [1:0] fld(input logic [7:0] r, input int pos);
    return r[pos +: 2];
  endfunction
endpackage
`default_nettype wire

// [ctm_csi2_tx_timing_lane_map.sv]
// data lane burst sequencer with programmable timing, lane count and byte routing
`timescale 1ns/100ps
`default_nettype none
module ctm_csi2_tx_timing_lane_map (
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  input  wire logic                               ce,
  input  wire logic [7:0]                         reg_addr,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  input  wire logic [7:0]                         reg_wdata,
  output var  logic [7:0]                         reg_rdata,
  input  wire logic [31:0]                        pix_bytes,
  input  wire logic                               video_data_enable,
  input  wire logic                               hsync_in,
  input  wire logic                               link_clk_pin,
  output var  ctm_pkg::ctm_lane_out_t [3:0]       lane_out,
  output var  ctm_pkg::ctm_lane_mode_t            clk_lane_mode,
  output var  logic                               burst_active
);
  ctm_pkg::ctm_cfg_t              cfg;
  ctm_pkg::ctm_cfg_t              next_cfg;
  ctm_pkg::ctm_cfg_t              act;
  ctm_pkg::ctm_cfg_t              next_act;
  logic [7:0]                     next_rdata;
  logic                           lk_meta;
  logic                           lk_sync;
  logic                           lk_prev;
  logic                           link_edge;
  logic                           en_sel;
  logic                           phase_done;
  ctm_pkg::ctm_state_t            state;
  ctm_pkg::ctm_state_t            next_state;
  logic [ctm_pkg::CYC_W-1:0]      cyc;
  logic [ctm_pkg::CYC_W-1:0]      next_cyc;
  logic [ctm_pkg::TICK_W-1:0]     tick;
  logic [ctm_pkg::TICK_W-1:0]     next_tick;
  ctm_pkg::ctm_lane_out_t [3:0]   next_lane;
  ctm_pkg::ctm_lane_mode_t        next_clk_mode;

  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  function automatic logic [ctm_pkg::CYC_W-1:0] load_cyc(input ctm_pkg::ctm_state_t s,
                                                         input ctm_pkg::ctm_cfg_t c);
    int ns;
    ns = ctm_pkg::CLK_PERIOD_NS;
    case (s)
      ctm_pkg::ST_LPX:      ns = ctm_pkg::LPX_NS[ctm_pkg::fld(c.hs_timing, ctm_pkg::LPX_POS)];
      ctm_pkg::ST_CLK_PREP: ns = ctm_pkg::CLKPREP_NS[ctm_pkg::fld(c.clk_timing, ctm_pkg::CLKPREP_POS)];
      ctm_pkg::ST_PREP:     ns = ctm_pkg::PREP_NS[ctm_pkg::fld(c.hs_timing, ctm_pkg::PREP_POS)];
      ctm_pkg::ST_ZERO:     ns = ctm_pkg::ZERO_NS[ctm_pkg::fld(c.hs_timing, ctm_pkg::ZERO_POS)];
      ctm_pkg::ST_TRAIL:    ns = ctm_pkg::TRAIL_NS[ctm_pkg::fld(c.hs_timing, ctm_pkg::TRAIL_POS)];
      default:              ns = ctm_pkg::CLK_PERIOD_NS;
    endcase
    return ctm_pkg::CYC_W'(ctm_pkg::cyc_of(ns) - 1);
  endfunction

  function automatic logic [ctm_pkg::TICK_W-1:0] load_tick(input ctm_pkg::ctm_state_t s);
    int ui;
    ui = 0;
    case (s)
      ctm_pkg::ST_PREP:  ui = ctm_pkg::PREP_UI;
      ctm_pkg::ST_ZERO:  ui = ctm_pkg::ZERO_UI;
      ctm_pkg::ST_TRAIL: ui = ctm_pkg::TRAIL_UI;
      default:           ui = 0;
    endcase
    return ctm_pkg::TICK_W'(ctm_pkg::tick_of(ui));
  endfunction

  function automatic logic [7:0] routed(input logic [7:0] map, input logic [31:0] b, input int lane);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < ctm_pkg::NUM_LANES; k++) begin
      if (int'(map[2*k +: 2]) == lane) begin
        r = b[8*k +: 8];
      end
    end
    return r;
  endfunction

  function automatic ctm_pkg::ctm_lane_mode_t data_mode(input ctm_pkg::ctm_state_t s);
    case (s)
      ctm_pkg::ST_IDLE:     return ctm_pkg::LANE_STOP;
      ctm_pkg::ST_LPX:      return ctm_pkg::LANE_LP01;
      ctm_pkg::ST_CLK_PREP: return ctm_pkg::LANE_LP01;
      ctm_pkg::ST_PREP:     return ctm_pkg::LANE_LP00;
      default:              return ctm_pkg::LANE_HS;
    endcase
  endfunction

  // -------------------------------------------------
  // register file
  // -------------------------------------------------
  always_comb begin
    next_cfg   = cfg;
    next_rdata = reg_rdata;
    if (reg_wr) begin
      case (reg_addr)
        ctm_pkg::CLK_TIMING_OFS: next_cfg.clk_timing = {reg_wdata[7:4], 4'h0};
        ctm_pkg::HS_TIMING_OFS:  next_cfg.hs_timing = reg_wdata;
        ctm_pkg::LANE_CTRL_OFS:  next_cfg.lane_ctrl = {1'b0, reg_wdata[6:4], ctm_pkg::LANE_CTRL_RSVD};
        ctm_pkg::LANE_MAP_OFS:   next_cfg.lane_map = reg_wdata;
        default:                 next_cfg = cfg;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ctm_pkg::CLK_TIMING_OFS: next_rdata = cfg.clk_timing;
        ctm_pkg::HS_TIMING_OFS:  next_rdata = cfg.hs_timing;
        ctm_pkg::LANE_CTRL_OFS:  next_rdata = cfg.lane_ctrl;
        ctm_pkg::LANE_MAP_OFS:   next_rdata = cfg.lane_map;
        ctm_pkg::SPARE_OFS:      next_rdata = ctm_pkg::SPARE_RST;
        default:                 next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg       <= {ctm_pkg::CLK_TIMING_RST, ctm_pkg::HS_TIMING_RST,
                    ctm_pkg::LANE_CTRL_RST, ctm_pkg::LANE_MAP_RST};
      reg_rdata <= 8'h00;
    end else if (ce) begin
      cfg       <= next_cfg;
      reg_rdata <= next_rdata;
    end
  end

  // -------------------------------------------------
  // link clock sampling
  // -------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lk_meta <= 1'b0;
      lk_sync <= 1'b0;
      lk_prev <= 1'b0;
    end else if (ce) begin
      lk_meta <= link_clk_pin;
      lk_sync <= lk_meta;
      lk_prev <= lk_sync;
    end
  end

  assign link_edge = lk_sync & ~lk_prev;

  assign en_sel = cfg.lane_ctrl[ctm_pkg::EN_SRC_POS] ? hsync_in : video_data_enable;

  // -------------------------------------------------
  // burst sequencer
  // -------------------------------------------------
  always_comb begin
    next_state    = state;
    next_cyc      = cyc;
    next_tick     = tick;
    next_act      = (state == ctm_pkg::ST_IDLE) ? cfg : act;
    next_lane     = lane_out;
    next_clk_mode = clk_lane_mode;
    phase_done    = (cyc == '0) && (tick == '0);
    case (state)
      ctm_pkg::ST_IDLE:     if (en_sel) next_state = ctm_pkg::ST_LPX;
      ctm_pkg::ST_LPX:      if (phase_done) next_state = ctm_pkg::ST_CLK_PREP;
      ctm_pkg::ST_CLK_PREP: if (phase_done) next_state = ctm_pkg::ST_PREP;
      ctm_pkg::ST_PREP:     if (phase_done) next_state = ctm_pkg::ST_ZERO;
      ctm_pkg::ST_ZERO:     if (phase_done) next_state = ctm_pkg::ST_SYNC;
      ctm_pkg::ST_SYNC:     if (link_edge) next_state = ctm_pkg::ST_PAYLOAD;
      ctm_pkg::ST_PAYLOAD:  if (link_edge && !en_sel) next_state = ctm_pkg::ST_TRAIL;
      ctm_pkg::ST_TRAIL:    if (phase_done) next_state = ctm_pkg::ST_IDLE;
      default:              next_state = ctm_pkg::ST_IDLE;
    endcase
    if (next_state != state) begin
      next_cyc  = load_cyc(next_state, next_act);
      next_tick = load_tick(next_state);
    end else if (cyc != '0) begin
      next_cyc = cyc - ctm_pkg::CYC_W'(1);
    end else if (tick != '0 && link_edge) begin
      next_tick = tick - ctm_pkg::TICK_W'(1);
    end
    next_clk_mode = (next_state == ctm_pkg::ST_IDLE) ? ctm_pkg::LANE_STOP :
                    (next_state == ctm_pkg::ST_LPX) ? ctm_pkg::LANE_LP01 :
                    (next_state == ctm_pkg::ST_CLK_PREP) ? ctm_pkg::LANE_LP00 : ctm_pkg::LANE_HS;
    for (int i = 0; i < ctm_pkg::NUM_LANES; i++) begin
      // lanes above the count are off
      if (i <= int'(next_act.lane_ctrl[ctm_pkg::COUNT_POS +: 2])) begin
        next_lane[i].mode = data_mode(next_state);
      end else begin
        next_lane[i].mode = ctm_pkg::LANE_STOP;
      end
      case (next_state)
        ctm_pkg::ST_ZERO:    next_lane[i].data = 8'h00;
        ctm_pkg::ST_SYNC:    next_lane[i].data = ctm_pkg::SYNC_BYTE;
        ctm_pkg::ST_PAYLOAD: if (link_edge) next_lane[i].data = routed(next_act.lane_map, pix_bytes, i);
        ctm_pkg::ST_TRAIL:   if (state != ctm_pkg::ST_TRAIL) next_lane[i].data = {8{~lane_out[i].data[7]}};
        default:             next_lane[i].data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state         <= ctm_pkg::ST_IDLE;
      cyc           <= '0;
      tick          <= '0;
      act           <= {ctm_pkg::CLK_TIMING_RST, ctm_pkg::HS_TIMING_RST,
                        ctm_pkg::LANE_CTRL_RST, ctm_pkg::LANE_MAP_RST};
      lane_out      <= '0;
      clk_lane_mode <= ctm_pkg::LANE_STOP;
      burst_active  <= 1'b0;
    end else if (ce) begin
      state         <= next_state;
      cyc           <= next_cyc;
      tick          <= next_tick;
      act           <= next_act;
      lane_out      <= next_lane;
      clk_lane_mode <= next_clk_mode;
      burst_active  <= (next_state != ctm_pkg::ST_IDLE);
    end
  end

  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  chk_prep_load: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(state) && state == ctm_pkg::ST_PREP |->
      cyc == ctm_pkg::CYC_W'(ctm_pkg::cyc_of(ctm_pkg::PREP_NS[act.hs_timing[7:6]]) - 1) && tick == 3'h1)
    else $error("prepare phase loaded wrong length");
  chk_zero_load: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(state) && state == ctm_pkg::ST_ZERO |->
      cyc == ctm_pkg::CYC_W'(ctm_pkg::cyc_of(ctm_pkg::ZERO_NS[act.hs_timing[5:4]]) - 1) && tick == 3'h4)
    else $error("zero phase loaded wrong length");
  chk_trail_load: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(state) && state == ctm_pkg::ST_TRAIL |->
      cyc == ctm_pkg::CYC_W'(ctm_pkg::cyc_of(ctm_pkg::TRAIL_NS[act.hs_timing[3:2]]) - 1))
    else $error("trail phase loaded wrong length");
  chk_lpx_hold: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state == ctm_pkg::ST_LPX && cyc != '0 |=> state == ctm_pkg::ST_LPX || !$past(ce))
    else $error("low-power period cut short");
  chk_src_start: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state == ctm_pkg::ST_IDLE && cfg.lane_ctrl[6] && hsync_in |=> state == ctm_pkg::ST_LPX)
    else $error("sync input did not start a burst");
  chk_lane_off: assert property (@(posedge sys_clk) disable iff (rst)
    act.lane_ctrl[5:4] != 2'h3 |-> lane_out[3].mode == ctm_pkg::LANE_STOP)
    else $error("disabled lane left stop state");
  chk_byte3_route: assert property (@(posedge sys_clk) disable iff (rst)
    ce && link_edge && next_state == ctm_pkg::ST_PAYLOAD |=>
      lane_out[act.lane_map[7:6]].data == $past(pix_bytes[31:24]))
    else $error("byte 3 on wrong lane");
  chk_byte2_route: assert property (@(posedge sys_clk) disable iff (rst)
    ce && link_edge && next_state == ctm_pkg::ST_PAYLOAD |=>
      lane_out[act.lane_map[5:4]].data == $past(pix_bytes[23:16]))
    else $error("byte 2 on wrong lane");
  chk_byte1_route: assert property (@(posedge sys_clk) disable iff (rst)
    ce && link_edge && next_state == ctm_pkg::ST_PAYLOAD |=>
      lane_out[act.lane_map[3:2]].data == $past(pix_bytes[15:8]))
    else $error("byte 1 on wrong lane");
  chk_byte0_route: assert property (@(posedge sys_clk) disable iff (rst)
    ce && link_edge && next_state == ctm_pkg::ST_PAYLOAD |=>
      lane_out[act.lane_map[1:0]].data == $past(pix_bytes[7:0]))
    else $error("byte 0 on wrong lane");
  chk_rsvd_read: assert property (@(posedge sys_clk) disable iff (rst)
    ce && reg_rd && reg_addr == ctm_pkg::LANE_CTRL_OFS |=> reg_rdata[3:0] == 4'h7 && !reg_rdata[7])
    else $error("reserved bits read wrong");
  chk_clk_prep: assert property (@(posedge sys_clk) disable iff (rst)
    state == ctm_pkg::ST_CLK_PREP |-> clk_lane_mode == ctm_pkg::LANE_LP00)
    else $error("clock lane not in prepare state");
  chk_mid_burst: assert property (@(posedge sys_clk) disable iff (rst)
    state != ctm_pkg::ST_IDLE |=> $stable(act))
    else $error("settings changed inside a burst");
  chk_lpx_load: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(state) && state == ctm_pkg::ST_LPX |->
      cyc == ctm_pkg::CYC_W'(ctm_pkg::cyc_of(ctm_pkg::LPX_NS[act.hs_timing[1:0]]) - 1) && tick == 3'h0)
    else $error("low-power period loaded wrong length");
  chk_clkprep_load: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(state) && state == ctm_pkg::ST_CLK_PREP |->
      cyc == ctm_pkg::CYC_W'(ctm_pkg::cyc_of(ctm_pkg::CLKPREP_NS[act.clk_timing[7:6]]) - 1))
    else $error("clock prepare loaded wrong length");
  chk_trail_hold: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state == ctm_pkg::ST_TRAIL && !phase_done |=> state == ctm_pkg::ST_TRAIL)
    else $error("trail state cut short");
  chk_src_normal: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state == ctm_pkg::ST_IDLE && !cfg.lane_ctrl[6] && video_data_enable |=> state == ctm_pkg::ST_LPX)
    else $error("data enable did not start a burst");
  chk_lane_zero_on: assert property (@(posedge sys_clk) disable iff (rst)
    state == ctm_pkg::ST_PREP |-> lane_out[0].mode == ctm_pkg::LANE_LP00)
    else $error("lane 0 not enabled");
  chk_lane_one_off: assert property (@(posedge sys_clk) disable iff (rst)
    act.lane_ctrl[5:4] == 2'h0 |-> lane_out[1].mode == ctm_pkg::LANE_STOP)
    else $error("lane 1 active above lane count");
  chk_lane_two_off: assert property (@(posedge sys_clk) disable iff (rst)
    act.lane_ctrl[5:4] < 2'h2 |-> lane_out[2].mode == ctm_pkg::LANE_STOP)
    else $error("lane 2 active above lane count");
  chk_idle_stop: assert property (@(posedge sys_clk) disable iff (rst)
    state == ctm_pkg::ST_IDLE |-> lane_out[0].mode == ctm_pkg::LANE_STOP && clk_lane_mode == ctm_pkg::LANE_STOP)
    else $error("lanes not in stop state while idle");
endmodule
`default_nettype wire

// [ctm_rx_model.sv]
// receiver-side model: times lane phases and keeps the first payload byte per lane
`timescale 1ns/100ps
`default_nettype none
module ctm_rx_model (
  input  wire logic                         sys_clk,
  input  wire ctm_pkg::ctm_lane_out_t [3:0] lane_out,
  input  wire ctm_pkg::ctm_lane_mode_t      clk_lane_mode,
  output var  logic [4:0][7:0]              n,
  output var  logic [3:0]                   act,
  output var  logic [3:0]                   got,
  output var  logic [31:0]                  first
);
  ctm_pkg::ctm_lane_mode_t prev_clk;
  logic [3:0]              sync;
  logic                    hs0;
  assign hs0 = lane_out[0].mode == ctm_pkg::LANE_HS;
  // ---------------------------------------
  // phase counters: lpx, clock prep, data prep, zero, trail
  // ---------------------------------------
  always @(posedge sys_clk) begin
    prev_clk <= clk_lane_mode;
    if (clk_lane_mode == ctm_pkg::LANE_LP01 && prev_clk == ctm_pkg::LANE_STOP) begin
      n <= 40'h1;
      act <= 4'h0;
      got <= 4'h0;
      sync <= 4'h0;
    end else begin
      if (clk_lane_mode == ctm_pkg::LANE_LP01) n[0] <= n[0] + 8'h01;
      if (clk_lane_mode == ctm_pkg::LANE_LP00) n[1] <= n[1] + 8'h01;
      if (lane_out[0].mode == ctm_pkg::LANE_LP00) n[2] <= n[2] + 8'h01;
      if (hs0 && lane_out[0].data == 8'h00 && !sync[0]) n[3] <= n[3] + 8'h01;
      if (hs0 && got[0] && lane_out[0].data != first[7:0]) n[4] <= n[4] + 8'h01;
      for (int l = 0; l < 4; l++) begin
        if (lane_out[l].mode != ctm_pkg::LANE_STOP) act[l] <= 1'b1;
        if (lane_out[l].mode == ctm_pkg::LANE_HS && lane_out[l].data == 8'hb8) sync[l] <= 1'b1;
        else if (lane_out[l].mode == ctm_pkg::LANE_HS && sync[l] && !got[l]) begin
          got[l] <= 1'b1;
          first[8*l +: 8] <= lane_out[l].data;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [ctm_testbench.sv]
// self-checking bench for the lane timing and byte-to-lane map block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [7:0] RA [6] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h70};
  localparam logic [7:0] RV [6] = '{8'h00, 8'h00, 8'h17, 8'he4, 8'h00, 8'h00};
  localparam logic [7:0] WA [6] = '{8'h65, 8'h67, 8'h63, 8'h64, 8'h66, 8'h70};
  localparam logic [7:0] WD [6] = '{8'hff, 8'hff, 8'hff, 8'ha5, 8'h1b, 8'hff};
  localparam logic [7:0] WE [6] = '{8'h77, 8'h00, 8'hf0, 8'ha5, 8'h1b, 8'h00};
  logic                         sys_clk;
  logic                         rst;
  logic                         ce;
  logic [7:0]                   reg_addr;
  logic                         reg_wr;
  logic                         reg_rd;
  logic [7:0]                   reg_wdata;
  logic [7:0]                   reg_rdata;
  logic [31:0]                  pix_bytes;
  logic                         video_data_enable;
  logic                         hsync_in;
  logic                         link_clk_pin;
  ctm_pkg::ctm_lane_out_t [3:0] lane_out;
  ctm_pkg::ctm_lane_mode_t      clk_lane_mode;
  logic                         burst_active;
  logic [4:0][7:0]              rx_n;
  logic [3:0]                   rx_act;
  logic [3:0]                   rx_got;
  logic [31:0]                  rx_first;
  int                           err_total = 0;
  int                           checked = 0;
  int                           cyc = 0;

  ctm_csi2_tx_timing_lane_map dut_u (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pix_bytes(pix_bytes),
    .video_data_enable(video_data_enable), .hsync_in(hsync_in), .link_clk_pin(link_clk_pin),
    .lane_out(lane_out), .clk_lane_mode(clk_lane_mode), .burst_active(burst_active)
  );
  ctm_rx_model rx_u (
    .sys_clk(sys_clk), .lane_out(lane_out), .clk_lane_mode(clk_lane_mode),
    .n(rx_n), .act(rx_act), .got(rx_got), .first(rx_first)
  );

  always #10 sys_clk = ~sys_clk;
  always #80 link_clk_pin = ~link_clk_pin;

  // ---------------------------------------
  // common tasks
  // ---------------------------------------
  task automatic close_out();
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // ---------------------------------------
  // scenarios
  // ---------------------------------------
  task automatic t_regs();
    logic [7:0] v;
    for (int i = 0; i < 6; i++) begin
      rd(RA[i], v);
      check(v, RV[i]);
    end
    for (int i = 0; i < 6; i++) begin
      wr(WA[i], WD[i]);
      rd(WA[i], v);
      check(v, WE[i]);
    end
  endtask

  task automatic t_src(input logic src);
    wr(8'h65, {1'b0, src, 2'b01, 4'h7});
    @(posedge sys_clk);
    if (src) video_data_enable <= 1'b1;
    else hsync_in <= 1'b1;
    repeat (30) @(posedge sys_clk);
    check(burst_active, 1'b0);
    video_data_enable <= 1'b0;
    hsync_in <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic burst(input logic [7:0] hs, input logic [1:0] ck, input logic [1:0] cnt,
                       input logic [7:0] map, input logic src);
    int i;
    int k;
    int a;
    wr(8'h63, {ck, 6'h00});
    wr(8'h64, hs);
    wr(8'h65, {1'b0, src, cnt, 4'h7});
    wr(8'h66, map);
    @(posedge sys_clk);
    if (src) hsync_in <= 1'b1;
    else video_data_enable <= 1'b1;
    for (i = 0; i < 50 && burst_active !== 1'b1; i++) @(posedge sys_clk);
    check(burst_active, 1'b1);
    wr(8'h64, ~hs);
    wr(8'h65, {1'b0, src, ~cnt, 4'h7});
    wr(8'h66, ~map);
    for (i = 0; i < 600 && rx_got[0] !== 1'b1; i++) @(posedge sys_clk);
    @(posedge sys_clk);
    video_data_enable <= 1'b0;
    hsync_in <= 1'b0;
    for (i = 0; i < 600 && burst_active !== 1'b0; i++) @(posedge sys_clk);
    check(burst_active, 1'b0);
    k = hs[1:0];
    check(rx_n[0], (64 * k + 83) / 20);
    k = ck;
    check(rx_n[1], (83 + 8 * k) / 20);
    k = hs[7] ? 2 : hs[6];
    a = (83 + 8 * k) / 20;
    check(rx_n[2] >= a && rx_n[2] <= a + 10, 1'b1);
    a = (ctm_pkg::ZERO_NS[hs[5:4]] + 19) / 20 + 24;
    check(rx_n[3] >= a && rx_n[3] <= a + 12, 1'b1);
    a = (ctm_pkg::TRAIL_NS[hs[3:2]] + 19) / 20;
    check(rx_n[4] >= a && rx_n[4] <= a + 10, 1'b1);
    check(rx_act, (4'h2 << cnt) - 4'h1);
    check(rx_got, (4'h2 << cnt) - 4'h1);
    for (k = 0; k < 4; k++) begin
      if (map[2*k +: 2] <= cnt) begin
        check(rx_first[8*map[2*k +: 2] +: 8], pix_bytes[8*k +: 8]);
      end
    end
  endtask

  task automatic t_hold();
    logic [7:0] v;
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(8'h66, 8'h00);
    ce <= 1'b1;
    rd(8'h66, v);
    check(v, 8'h1b); // write ignored while frozen
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    sys_clk = 1'b0;
    link_clk_pin = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    pix_bytes = 32'h4c3b2a19;
    video_data_enable = 1'b0;
    hsync_in = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_hold();
    t_src(1'b0);
    t_src(1'b1);
    burst(8'h00, 2'b00, 2'b01, 8'he4, 1'b0);
    burst(8'hff, 2'b11, 2'b11, 8'h1b, 1'b0);
    burst(8'h56, 2'b01, 2'b10, 8'h9c, 1'b1);
    burst(8'ha9, 2'b10, 2'b00, 8'h4e, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
